/* hw/pea_top.sv */
// power and energy accumulator with avalon-mm register slave
//
// Summary of operation
// - power product is signed sense times signed bus, 32-bit signed
// - product and accumulator sum arithmetic is signed two's complement; the tally sum is unsigned
// - products are summed into a 56-bit accumulator
// - adaptive mode shifts slow-rate samples left to mimic 8192 sps
// - adaptive mode advances the tally by the same scale per sample
// - adaptive scaling only while its enable bit is one
// - unipolar channels read back as 16-bit unsigned results
// - bipolar channels read back as 16-bit signed results
// - sample tally is 32 bits wide
// - accumulator and tally saturate and hold until cleared
// - full or general refresh restarts accumulator from the base value
// - top six accumulator bits above threshold field raise an alert
// - tally alert at three quarters, seven eighths, 15/16 or full
// - 2-bit source field picks power, bus or sense summation
// - voltage-only refresh leaves accumulated data intact
// - half range by shifting, product keeps full precision
// - two independent 2-bit range fields, bus and sense
// - source codes: bus 10, sense 01, power 00, power at reset
// - range code 10 selects bipolar half range
// - each conversion end adds the value and advances the tally
//
// Decided for this implementation: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
module pea_top (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // avalon-mm slave
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // samples from the conversion sequencer
  input wire logic sample_valid_i,
  input wire logic [15:0] bus_sample_i,
  input wire logic [15:0] sense_sample_i,
  // fullness alert
  output logic alert_o
);

  pea_pkg::pea_state_t st_ff;
  pea_pkg::pea_state_t nxt_st;

  pea_fmt_if bus_fmt ();
  pea_fmt_if sns_fmt ();

  logic wr_go;
  logic rd_go;
  logic cmd_hit;
  logic ref_full;
  logic ref_any;
  logic [31:0] rd_word;
  logic [3:0] shamt;
  logic [55:0] sel_val;
  logic [55:0] addend;
  logic [32:0] inc;
  logic [55:0] acc_base;
  logic [31:0] cnt_base;
  logic acc_sat_base;
  logic cnt_sat_base;
  logic [56:0] acc_sum;
  logic [32:0] cnt_sum;
  logic [31:0] cnt_lim_val;

  // byte-enable merge of a written word
  function automatic logic [31:0] pea_merge(input logic [31:0] old_w,
                                            input logic [31:0] new_w,
                                            input logic [3:0] be);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // adaptive shift for each programmed rate
  function automatic logic [3:0] pea_shift(input logic [2:0] rate);
    logic [3:0] sh;
    case (rate)
      pea_pkg::PEA_RATE_4096: begin
        sh = pea_pkg::PEA_SH_4096;
      end
      pea_pkg::PEA_RATE_1024: begin
        sh = pea_pkg::PEA_SH_1024;
      end
      pea_pkg::PEA_RATE_256: begin
        sh = pea_pkg::PEA_SH_256;
      end
      pea_pkg::PEA_RATE_64: begin
        sh = pea_pkg::PEA_SH_64;
      end
      pea_pkg::PEA_RATE_8: begin
        sh = pea_pkg::PEA_SH_8;
      end
      default: begin
        sh = pea_pkg::PEA_SH_8192;
      end
    endcase
    return sh;
  endfunction

  // result formatters, one per channel
  pea_range_fmt u_bus_fmt (
    .port(bus_fmt.fmt)
  );
  pea_range_fmt u_sns_fmt (
    .port(sns_fmt.fmt)
  );

  // formatter inputs from the latest samples
  assign bus_fmt.raw = st_ff.s1_bus;
  assign bus_fmt.range = st_ff.bus_rng;
  assign sns_fmt.raw = st_ff.s1_sns;
  assign sns_fmt.range = st_ff.sns_rng;

  // bus handshake: one wait cycle on every access
  assign wr_go = avs_write_i & st_ff.ack;
  assign rd_go = avs_read_i & ~st_ff.ack;
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~st_ff.ack;
  assign avs_readdata_o = st_ff.rdata;
  assign alert_o = st_ff.alert_acc | st_ff.alert_cnt;

  // refresh commands
  assign cmd_hit = wr_go & (avs_address_i == pea_pkg::PEA_OFS_CMD);
  assign ref_full = cmd_hit & avs_byteenable_i[0] &
                    (avs_writedata_i[pea_pkg::PEA_CMD_FULL_BIT] |
                     avs_writedata_i[pea_pkg::PEA_CMD_GEN_BIT]);
  assign ref_any = ref_full | (cmd_hit & avs_byteenable_i[0] &
                   avs_writedata_i[pea_pkg::PEA_CMD_VOLT_BIT]);

  // read multiplexer, unmapped offsets read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    case (avs_address_i)
      pea_pkg::PEA_OFS_CTRL: begin
        rd_word[pea_pkg::PEA_CTRL_SRC_LSB +: 2] = st_ff.src;
        rd_word[pea_pkg::PEA_CTRL_AA_BIT] = st_ff.aa;
        rd_word[pea_pkg::PEA_CTRL_RATE_LSB +: 3] = st_ff.rate;
      end
      pea_pkg::PEA_OFS_RANGE: begin
        rd_word[pea_pkg::PEA_RANGE_BUS_LSB +: 2] = st_ff.bus_rng;
        rd_word[pea_pkg::PEA_RANGE_SNS_LSB +: 2] = st_ff.sns_rng;
      end
      pea_pkg::PEA_OFS_BASE_LO: begin
        rd_word = st_ff.base[31:0];
      end
      pea_pkg::PEA_OFS_BASE_HI: begin
        rd_word[23:0] = st_ff.base[55:32];
      end
      pea_pkg::PEA_OFS_FULL: begin
        rd_word[5:0] = st_ff.full_thr;
        rd_word[pea_pkg::PEA_FULL_CNT_LSB +: 2] = st_ff.cnt_lim;
      end
      pea_pkg::PEA_OFS_BUS: begin
        rd_word[15:0] = st_ff.rd_bus;
      end
      pea_pkg::PEA_OFS_SENSE: begin
        rd_word[15:0] = st_ff.rd_sns;
      end
      pea_pkg::PEA_OFS_POWER: begin
        rd_word = st_ff.rd_pwr;
      end
      pea_pkg::PEA_OFS_ACC_LO: begin
        rd_word = st_ff.rd_acc[31:0];
      end
      pea_pkg::PEA_OFS_ACC_HI: begin
        rd_word[23:0] = st_ff.rd_acc[55:32];
      end
      pea_pkg::PEA_OFS_TALLY: begin
        rd_word = st_ff.rd_tally;
      end
      pea_pkg::PEA_OFS_STATUS: begin
        rd_word[3:0] = {st_ff.cnt_sat, st_ff.acc_sat,
                        st_ff.alert_cnt, st_ff.alert_acc};
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  // addend selection and adaptive scaling
  always_comb begin
    shamt = st_ff.aa ? pea_shift(st_ff.rate) : 4'h0;
    case (st_ff.src)
      pea_pkg::PEA_SRC_SENSE: begin
        sel_val = {{40{st_ff.s1_sns[15]}}, st_ff.s1_sns};
      end
      pea_pkg::PEA_SRC_BUS: begin
        sel_val = {{40{st_ff.s1_bus[15]}}, st_ff.s1_bus};
      end
      default: begin
        sel_val = {{24{st_ff.s1_pwr[31]}}, st_ff.s1_pwr};
      end
    endcase
    addend = sel_val << shamt;
    inc = 33'h0_0000_0001 << shamt;
  end

  // sums from the refreshed or running base
  always_comb begin
    acc_base = ref_full ? st_ff.base : st_ff.acc;
    cnt_base = ref_full ? 32'h0000_0000 : st_ff.tally;
    acc_sat_base = st_ff.acc_sat & ~ref_full;
    cnt_sat_base = st_ff.cnt_sat & ~ref_full;
    acc_sum = {acc_base[55], acc_base} + {addend[55], addend};
    cnt_sum = {1'b0, cnt_base} + inc;
    case (st_ff.cnt_lim)
      pea_pkg::PEA_CLIM_3Q: begin
        cnt_lim_val = pea_pkg::PEA_CNT_3Q;
      end
      pea_pkg::PEA_CLIM_7E: begin
        cnt_lim_val = pea_pkg::PEA_CNT_7E;
      end
      pea_pkg::PEA_CLIM_15S: begin
        cnt_lim_val = pea_pkg::PEA_CNT_15S;
      end
      default: begin
        cnt_lim_val = pea_pkg::PEA_CNT_MAX;
      end
    endcase
  end

  // next state
  always_comb begin
    nxt_st = st_ff;
    nxt_st.ack = (avs_read_i | avs_write_i) & ~st_ff.ack;
    if (rd_go) begin
      nxt_st.rdata = rd_word;
    end
    // configuration writes
    if (wr_go) begin
      case (avs_address_i)
        pea_pkg::PEA_OFS_CTRL: begin
          if (avs_byteenable_i[0]) begin
            nxt_st.src = avs_writedata_i[pea_pkg::PEA_CTRL_SRC_LSB +: 2];
            nxt_st.aa = avs_writedata_i[pea_pkg::PEA_CTRL_AA_BIT];
            nxt_st.rate = avs_writedata_i[pea_pkg::PEA_CTRL_RATE_LSB +: 3];
          end
        end
        pea_pkg::PEA_OFS_RANGE: begin
          if (avs_byteenable_i[0]) begin
            nxt_st.bus_rng =
              avs_writedata_i[pea_pkg::PEA_RANGE_BUS_LSB +: 2];
            nxt_st.sns_rng =
              avs_writedata_i[pea_pkg::PEA_RANGE_SNS_LSB +: 2];
          end
        end
        pea_pkg::PEA_OFS_BASE_LO: begin
          nxt_st.base[31:0] = pea_merge(st_ff.base[31:0],
                                        avs_writedata_i, avs_byteenable_i);
        end
        pea_pkg::PEA_OFS_BASE_HI: begin
          nxt_st.base[55:32] = 24'(pea_merge({8'h00, st_ff.base[55:32]},
                                   avs_writedata_i, avs_byteenable_i));
        end
        pea_pkg::PEA_OFS_FULL: begin
          if (avs_byteenable_i[0]) begin
            nxt_st.full_thr = avs_writedata_i[5:0];
            nxt_st.cnt_lim = avs_writedata_i[pea_pkg::PEA_FULL_CNT_LSB +: 2];
          end
        end
        default: begin
          nxt_st.src = st_ff.src;
        end
      endcase
    end
    // first stage: capture samples and form the product
    nxt_st.s1_vld = sample_valid_i;
    if (sample_valid_i) begin
      nxt_st.s1_bus = bus_sample_i;
      nxt_st.s1_sns = sense_sample_i;
      nxt_st.s1_pwr = 32'($signed(sense_sample_i) *
                          $signed(bus_sample_i));
    end
    // readable snapshot on any refresh
    if (ref_any) begin
      nxt_st.rd_bus = bus_fmt.shown;
      nxt_st.rd_sns = sns_fmt.shown;
      nxt_st.rd_pwr = st_ff.s1_pwr;
      nxt_st.rd_acc = st_ff.acc;
      nxt_st.rd_tally = st_ff.tally;
    end
    // voltage refresh alone never touches the sums
    nxt_st.acc = acc_base;
    nxt_st.tally = cnt_base;
    nxt_st.acc_sat = acc_sat_base;
    nxt_st.cnt_sat = cnt_sat_base;
    nxt_st.alert_acc = st_ff.alert_acc & ~ref_full;
    nxt_st.alert_cnt = st_ff.alert_cnt & ~ref_full;
    // second stage: accumulate at the end of each conversion
    if (st_ff.s1_vld) begin
      if (!acc_sat_base) begin
        if (acc_sum[56] != acc_sum[55]) begin
          nxt_st.acc = acc_sum[56] ? pea_pkg::PEA_ACC_NEG_MIN :
                                     pea_pkg::PEA_ACC_POS_MAX;
          nxt_st.acc_sat = 1'b1;
        end else begin
          nxt_st.acc = acc_sum[55:0];
        end
      end
      if (!cnt_sat_base) begin
        if (cnt_sum[32]) begin
          nxt_st.tally = pea_pkg::PEA_CNT_MAX;
          nxt_st.cnt_sat = 1'b1;
        end else begin
          nxt_st.tally = cnt_sum[31:0];
        end
      end
      // fullness alerts, set wins over a clearing refresh
      if (nxt_st.acc[55:50] > st_ff.full_thr) begin
        nxt_st.alert_acc = 1'b1;
      end
      if (nxt_st.tally >= cnt_lim_val) begin
        nxt_st.alert_cnt = 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff <= '0;
      st_ff.src <= pea_pkg::PEA_RST_SRC;
      st_ff.rate <= pea_pkg::PEA_RST_RATE;
      st_ff.bus_rng <= pea_pkg::PEA_RST_RNG;
      st_ff.sns_rng <= pea_pkg::PEA_RST_RNG;
      st_ff.full_thr <= pea_pkg::PEA_RST_FULL_THR;
      st_ff.cnt_lim <= pea_pkg::PEA_RST_CNT_LIM;
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule

/* hw/pea_pkg.sv */
// shared constants and types of the power and energy accumulator
package pea_pkg;

  // register byte offsets
  localparam logic [5:0] PEA_OFS_CTRL = 6'h00;
  localparam logic [5:0] PEA_OFS_RANGE = 6'h04;
  localparam logic [5:0] PEA_OFS_CMD = 6'h08;
  localparam logic [5:0] PEA_OFS_BASE_LO = 6'h0c;
  localparam logic [5:0] PEA_OFS_BASE_HI = 6'h10;
  localparam logic [5:0] PEA_OFS_FULL = 6'h14;
  localparam logic [5:0] PEA_OFS_BUS = 6'h18;
  localparam logic [5:0] PEA_OFS_SENSE = 6'h1c;
  localparam logic [5:0] PEA_OFS_POWER = 6'h20;
  localparam logic [5:0] PEA_OFS_ACC_LO = 6'h24;
  localparam logic [5:0] PEA_OFS_ACC_HI = 6'h28;
  localparam logic [5:0] PEA_OFS_TALLY = 6'h2c;
  localparam logic [5:0] PEA_OFS_STATUS = 6'h30;

  // control field positions
  localparam int PEA_CTRL_SRC_LSB = 0;
  localparam int PEA_CTRL_AA_BIT = 2;
  localparam int PEA_CTRL_RATE_LSB = 3;
  localparam int PEA_RANGE_BUS_LSB = 0;
  localparam int PEA_RANGE_SNS_LSB = 2;
  localparam int PEA_FULL_CNT_LSB = 6;
  localparam int PEA_CMD_FULL_BIT = 0;
  localparam int PEA_CMD_VOLT_BIT = 1;
  localparam int PEA_CMD_GEN_BIT = 2;

  // accumulate source encodings
  localparam logic [1:0] PEA_SRC_POWER = 2'h0;
  localparam logic [1:0] PEA_SRC_SENSE = 2'h1;
  localparam logic [1:0] PEA_SRC_BUS = 2'h2;

  // channel range encodings
  localparam logic [1:0] PEA_RNG_UNI = 2'h0;
  localparam logic [1:0] PEA_RNG_BI = 2'h1;
  localparam logic [1:0] PEA_RNG_HALF = 2'h2;

  // sample rate codes and adaptive shift of each (log2 of 8192/rate)
  localparam logic [2:0] PEA_RATE_8192 = 3'h0;
  localparam logic [2:0] PEA_RATE_4096 = 3'h1;
  localparam logic [2:0] PEA_RATE_1024 = 3'h2;
  localparam logic [2:0] PEA_RATE_256 = 3'h3;
  localparam logic [2:0] PEA_RATE_64 = 3'h4;
  localparam logic [2:0] PEA_RATE_8 = 3'h5;
  localparam logic [3:0] PEA_SH_8192 = 4'h0;
  localparam logic [3:0] PEA_SH_4096 = 4'h1;
  localparam logic [3:0] PEA_SH_1024 = 4'h3;
  localparam logic [3:0] PEA_SH_256 = 4'h5;
  localparam logic [3:0] PEA_SH_64 = 4'h7;
  localparam logic [3:0] PEA_SH_8 = 4'ha;

  // sample tally fullness levels
  localparam logic [1:0] PEA_CLIM_3Q = 2'h0;
  localparam logic [1:0] PEA_CLIM_7E = 2'h1;
  localparam logic [1:0] PEA_CLIM_15S = 2'h2;
  localparam logic [31:0] PEA_CNT_3Q = 32'hc000_0000;
  localparam logic [31:0] PEA_CNT_7E = 32'he000_0000;
  localparam logic [31:0] PEA_CNT_15S = 32'hf000_0000;
  localparam logic [31:0] PEA_CNT_MAX = 32'hffff_ffff;

  // accumulator limits
  localparam logic [55:0] PEA_ACC_POS_MAX = 56'h7f_ffff_ffff_ffff;
  localparam logic [55:0] PEA_ACC_NEG_MIN = 56'h80_0000_0000_0000;

  // reset values
  localparam logic [1:0] PEA_RST_SRC = PEA_SRC_POWER;
  localparam logic [2:0] PEA_RST_RATE = PEA_RATE_1024;
  localparam logic [1:0] PEA_RST_RNG = PEA_RNG_UNI;
  localparam logic [5:0] PEA_RST_FULL_THR = 6'h3f;
  localparam logic [1:0] PEA_RST_CNT_LIM = 2'h3;

  // whole state of the top module
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [1:0] src;
    logic aa;
    logic [2:0] rate;
    logic [1:0] bus_rng;
    logic [1:0] sns_rng;
    logic [55:0] base;
    logic [5:0] full_thr;
    logic [1:0] cnt_lim;
    logic s1_vld;
    logic [15:0] s1_bus;
    logic [15:0] s1_sns;
    logic [31:0] s1_pwr;
    logic [55:0] acc;
    logic [31:0] tally;
    logic acc_sat;
    logic cnt_sat;
    logic alert_acc;
    logic alert_cnt;
    logic [15:0] rd_bus;
    logic [15:0] rd_sns;
    logic [31:0] rd_pwr;
    logic [55:0] rd_acc;
    logic [31:0] rd_tally;
  } pea_state_t;

endpackage

/* hw/pea_fmt_if.sv */
// carrier between the accumulator core and a result formatter
`timescale 1ns/1ps
interface pea_fmt_if;
  logic [15:0] raw;
  logic [1:0] range;
  logic [15:0] shown;
  modport src (output raw, output range, input shown);
  modport fmt (input raw, input range, output shown);
endinterface

/* hw/pea_range_fmt.sv */
// presents one internal signed sample in its channel's readable format
`timescale 1ns/1ps
module pea_range_fmt (
  // sample and range from the core
  pea_fmt_if.fmt port
);

  logic neg;
  logic ovf;

  // unsigned, signed or half range presentation
  always_comb begin
    neg = port.raw[15];
    ovf = port.raw[15] ^ port.raw[14];
    case (port.range)
      pea_pkg::PEA_RNG_UNI: begin
        // unsigned result, negatives clip at zero
        port.shown = neg ? 16'h0000 : {port.raw[14:0], 1'b0};
      end
      pea_pkg::PEA_RNG_HALF: begin
        // half range by one bit shift, saturating
        if (ovf) begin
          port.shown = neg ? 16'h8000 : 16'h7fff;
        end else begin
          port.shown = {port.raw[14:0], 1'b0};
        end
      end
      default: begin
        port.shown = port.raw;
      end
    endcase
  end

endmodule

/* verif/pea_seq_model.sv */
// conversion sequencer model feeding samples to the accumulator
`timescale 1ns/1ps
module pea_seq_model (
  // clock
  input wire logic ref_clk_i,
  // sample outputs
  output logic sample_valid_o,
  output logic [15:0] bus_sample_o,
  output logic [15:0] sense_sample_o
);
  // quiet lines at time zero
  initial begin
    sample_valid_o = 1'b0;
    bus_sample_o = 16'h0;
    sense_sample_o = 16'h0;
  end

  // one conversion end; repeated calls give back-to-back samples
  task automatic send(input logic [15:0] b, input logic [15:0] s);
    sample_valid_o <= 1'b1;
    bus_sample_o <= b;
    sense_sample_o <= s;
    @(posedge ref_clk_i);
  endtask

  // idle gap; data lines no longer hold the last sample
  task automatic idle(input int n);
    sample_valid_o <= 1'b0;
    bus_sample_o <= ~bus_sample_o;
    sense_sample_o <= ~sense_sample_o;
    repeat (n) @(posedge ref_clk_i);
  endtask
endmodule

/* verif/pea_top_asserts.sv */
// checker for the accumulator's register and alert ports
`timescale 1ns/1ps
module pea_top_asserts (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // register bus
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // samples and alert
  input wire logic sample_valid_i,
  input wire logic alert_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  logic [3:0] vh_ff;
  logic [2:0] ch_ff;
  logic clr_now;
  logic rd_ok;

  // accepted read and accepted clearing refresh
  assign rd_ok = avs_read_i && !avs_waitrequest_o;
  assign clr_now = avs_write_i && !avs_waitrequest_o &&
    avs_address_i == pea_pkg::PEA_OFS_CMD &&
    (avs_writedata_i[pea_pkg::PEA_CMD_FULL_BIT] ||
    avs_writedata_i[pea_pkg::PEA_CMD_GEN_BIT]);

  // history of samples and clearing refreshes
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      vh_ff <= 4'h0;
      ch_ff <= 3'h0;
    end else begin
      vh_ff <= {vh_ff[2:0], sample_valid_i};
      ch_ff <= {ch_ff[1:0], clr_now};
    end
  end

  a_alert_cause: assert property ($rose(alert_o) |-> vh_ff != 4'h0)
    else $error("alert rose with no recent sample");
  a_alert_sticky: assert property (alert_o && !clr_now &&
    ch_ff == 3'h0 |=> alert_o) else $error("alert dropped uncleared");
  a_clear_done: assert property (clr_now && !vh_ff[0] &&
    !sample_valid_i |=> ##1 !alert_o) else $error("alert not cleared");
  a_cmd_reads_zero: assert property (rd_ok &&
    avs_address_i == pea_pkg::PEA_OFS_CMD |-> avs_readdata_o == 32'h0)
    else $error("command register read not zero");
  a_acc_hi_width: assert property (rd_ok &&
    avs_address_i == pea_pkg::PEA_OFS_ACC_HI |-> avs_readdata_o[31:24]
    == 8'h0) else $error("accumulator wider than 56 bits");
  a_result_width: assert property (rd_ok &&
    (avs_address_i == pea_pkg::PEA_OFS_BUS ||
    avs_address_i == pea_pkg::PEA_OFS_SENSE) |->
    avs_readdata_o[31:16] == 16'h0) else $error("result over 16 bits");
  a_range_fields: assert property (rd_ok &&
    avs_address_i == pea_pkg::PEA_OFS_RANGE |->
    avs_readdata_o[31:4] == 28'h0) else $error("range reg too wide");
  a_ctrl_fields: assert property (rd_ok &&
    avs_address_i == pea_pkg::PEA_OFS_CTRL |->
    avs_readdata_o[31:6] == 26'h0) else $error("control reg too wide");
endmodule

bind pea_top pea_top_asserts u_chk (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o),
  .sample_valid_i(sample_valid_i), .alert_o(alert_o));

/* verif/tb_pea_top.sv */
// self-checking bench for the power and energy accumulator
`timescale 1ns/1ps
module tb_pea_top;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] adr = 6'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat;
  logic wait_req;
  logic alert;
  logic vld;
  logic [15:0] vb;
  logic [15:0] vs;
  int n_mismatch = 0;
  int tests_run = 0;
  int r;
  int ratio;
  int rates[6] = '{8192, 4096, 1024, 256, 64, 8};

  // 200 mhz clock
  always #2.5 ref_clk = ~ref_clk;

  pea_seq_model u_seq (.ref_clk_i(ref_clk), .sample_valid_o(vld),
    .bus_sample_o(vb), .sense_sample_o(vs));
  pea_top i_dut (.ref_clk_i(ref_clk), .rst_n_i(rst_n),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_byteenable_i(4'hf),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wait_req),
    .sample_valid_i(vld), .bus_sample_i(vb), .sense_sample_i(vs),
    .alert_o(alert));

  // counts, verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // register value compare
  task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // alert pin compare, sampled mid-cycle
  task automatic cmp_pin(string nm, logic e);
    logic g;
    @(negedge ref_clk);
    g = alert;
    @(posedge ref_clk);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
    end
  endtask

  // one transfer, held until waitrequest is seen low
  task automatic bus(logic w, logic [5:0] a, logic [31:0] d,
                     output logic [31:0] q);
    logic s;
    int k;
    rd <= ~w;
    wr <= w;
    adr <= a;
    wd <= d;
    s = 1'b1;
    // waitrequest and read data as they stand at each rising edge
    for (k = 0; k < 40 && s !== 1'b0; k++) begin
      @(posedge ref_clk);
      s = wait_req;
      q = rdat;
    end
    if (s !== 1'b0) begin
      n_mismatch++;
      results();
    end
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic wreg(logic [5:0] a, logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic chk(string nm, logic [5:0] a, logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    cmp(nm, e, q);
  endtask

  // voltage refresh, then accumulator and tally snapshots
  task automatic snap(logic [31:0] lo, logic [31:0] hi, logic [31:0] t);
    wreg(6'h08, 32'h2);
    chk("acc_lo", 6'h24, lo);
    chk("acc_hi", 6'h28, hi);
    chk("tally", 6'h2c, t);
  endtask

  // main sequence
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    chk("ctrl", 6'h00, 32'h10);
    chk("range", 6'h04, 32'h0);
    chk("full", 6'h14, 32'hff);
    chk("cmd", 6'h08, 32'h0);
    wreg(6'h18, 32'h1234);
    chk("bus_ro", 6'h18, 32'h0);
    chk("unmapped", 6'h34, 32'h0);
    $display("test reset done");
    // signed product, bus bipolar, sense half range
    wreg(6'h04, 32'h9);
    wreg(6'h08, 32'h1);
    u_seq.send(16'hfffd, 16'h0007);
    u_seq.idle(4);
    snap(32'hffff_ffeb, 32'h00ff_ffff, 32'h1);
    chk("power", 6'h20, 32'hffff_ffeb);
    chk("bus", 6'h18, 32'h0000_fffd);
    chk("sense", 6'h1c, 32'h0000_000e);
    $display("test power done");
    // sense source, unipolar, back-to-back, source change
    wreg(6'h04, 32'h0);
    wreg(6'h00, 32'h11);
    wreg(6'h08, 32'h1);
    u_seq.send(16'hfffe, 16'h0005);
    u_seq.send(16'hfffe, 16'h0005);
    u_seq.idle(4);
    wreg(6'h00, 32'h12);
    snap(32'ha, 32'h0, 32'h2);
    chk("bus", 6'h18, 32'h0);
    chk("sense", 6'h1c, 32'ha);
    chk("power", 6'h20, 32'hffff_fff6);
    wreg(6'h08, 32'h1);
    u_seq.send(16'h0003, 16'h0100);
    u_seq.idle(4);
    snap(32'h3, 32'h0, 32'h1);
    // spare source code sums power
    wreg(6'h00, 32'h3);
    wreg(6'h08, 32'h1);
    u_seq.send(16'h0003, 16'h0002);
    u_seq.idle(4);
    snap(32'h6, 32'h0, 32'h1);
    $display("test source done");
    // adaptive scaling per rate code, last pass with it off
    for (r = 0; r < 7; r++) begin
      ratio = (r == 6) ? 1 : 8192 / rates[r];
      wreg(6'h00, (r == 6) ? 32'h2a : 32'h6 | (32'(r) << 3));
      wreg(6'h08, 32'h1);
      u_seq.send(16'h0001, 16'h0);
      u_seq.idle(2 + r);
      snap(32'(ratio), 32'h0, 32'(ratio));
    end
    $display("test adaptive done");
    // base reload, saturation, alert and its clearing
    wreg(6'h00, 32'h2);
    wreg(6'h0c, 32'hffff_ffff);
    wreg(6'h10, 32'h007f_ffff);
    wreg(6'h14, 32'hde);
    wreg(6'h08, 32'h1);
    snap(32'hffff_ffff, 32'h007f_ffff, 32'h0);
    cmp_pin("alert", 1'b0);
    u_seq.send(16'h7fff, 16'h0);
    u_seq.idle(4);
    cmp_pin("alert", 1'b1);
    chk("status", 6'h30, 32'h5);
    snap(32'hffff_ffff, 32'h007f_ffff, 32'h1);
    wreg(6'h08, 32'h4);
    chk("status", 6'h30, 32'h0);
    cmp_pin("alert", 1'b0);
    snap(32'hffff_ffff, 32'h007f_ffff, 32'h0);
    $display("test saturation done");
    results();
  end
endmodule
